// file: dv/tb_usb_interrupt_enable_mask.sv
// Self-checking bench for the USB interrupt enable mask block
`timescale 1ns/1ps
module tb_usb_interrupt_enable_mask;
    import uiem_pkg::*;
    // ==========================================================
    // Signals
    logic clk_sys = 1'b0;
    logic rst = 1'b1;
    logic ce = 1'b1;
    logic [8:0] evt = 9'h000;
    logic [7:0] awaddr = 8'h00;
    logic [7:0] araddr = 8'h00;
    logic [31:0] wdata = 32'h0000_0000;
    logic awvalid = 1'b0;
    logic wvalid = 1'b0;
    logic bready = 1'b0;
    logic arvalid = 1'b0;
    logic rready = 1'b0;
    logic awready, wready, bvalid, arready, rvalid, usb_irq;
    logic [1:0] bresp, rresp;
    logic [31:0] rdata;
    int n_mismatch = 0;
    int samples_checked = 0;
    logic [1:0] resp;
    logic [31:0] rd;

    always #12.5 clk_sys = ~clk_sys;

    uiem_top dut (
        .clk_sys(clk_sys), .rst(rst), .ce(ce),
        .evt_stall(evt[7]), .evt_attach(evt[6]), .evt_resume(evt[5]),
        .evt_idle(evt[4]), .evt_token_done(evt[3]),
        .evt_frame_start(evt[2]), .evt_error_summary(evt[1]),
        .evt_bus_reset(evt[0]), .evt_unplug(evt[8]),
        .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
        .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arprot(3'h0),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .usb_irq(usb_irq)
    );

    // ==========================================================
    // Reporting
    task automatic end_of_test();
        $display("checked %0d, mismatches %0d", samples_checked, n_mismatch);
        if (n_mismatch == 0 && samples_checked > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic give_up();
        n_mismatch++;
        $display("[FAIL] t=%0t got=%h exp=%h", $time, 1'b0, 1'b1);
        end_of_test();
    endtask

    // ==========================================================
    // Bus master
    task automatic axi_wr(input logic [7:0] a, input logic [31:0] d,
                          output logic [1:0] r);
        int n;
        bit aw_ok;
        bit w_ok;
        aw_ok = 1'b0;
        w_ok = 1'b0;
        @(posedge clk_sys);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        for (n = 0; n < 64 && !(aw_ok && w_ok); n++) begin
            @(posedge clk_sys);
            if (!aw_ok && awready === 1'b1) begin
                awvalid <= 1'b0;
                aw_ok = 1'b1;
            end
            if (!w_ok && wready === 1'b1) begin
                wvalid <= 1'b0;
                w_ok = 1'b1;
            end
        end
        for (n = 0; n < 64 && bvalid !== 1'b1; n++) begin
            @(posedge clk_sys);
        end
        if (!(aw_ok && w_ok) || bvalid !== 1'b1) give_up();
        r = bresp;
        bready <= 1'b0;
    endtask

    task automatic axi_rd(input logic [7:0] a, output logic [31:0] d,
                          output logic [1:0] r);
        int n;
        bit ar_ok;
        ar_ok = 1'b0;
        @(posedge clk_sys);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        // Hold the address until an edge samples arready high
        for (n = 0; n < 64 && !ar_ok; n++) begin
            @(posedge clk_sys);
            if (arready === 1'b1) begin
                arvalid <= 1'b0;
                ar_ok = 1'b1;
            end
        end
        for (n = 0; n < 64 && ar_ok && rvalid !== 1'b1; n++) begin
            @(posedge clk_sys);
        end
        if (!ar_ok || rvalid !== 1'b1) give_up();
        d = rdata;
        r = rresp;
        rready <= 1'b0;
    endtask

    // One-cycle event pulse; index 8 is the detach source
    task automatic pulse(input int k);
        @(posedge clk_sys);
        evt[k] <= 1'b1;
        @(posedge clk_sys);
        evt[k] <= 1'b0;
        repeat (3) @(posedge clk_sys);
    endtask

    // ==========================================================
    // Scenarios
    task automatic test_reset_and_access();
        axi_rd(UIEM_OFF_ENABLE, rd, resp);
        check(rd, 32'h0000_0000);
        check({31'h0, usb_irq}, 32'h0000_0000);
        axi_wr(UIEM_OFF_ENABLE, 32'hFFFF_FFFF, resp);
        axi_rd(UIEM_OFF_ENABLE, rd, resp);
        check(rd, 32'h0000_00FF);
        axi_wr(UIEM_OFF_ENABLE, 32'h0000_A55A, resp);
        axi_rd(UIEM_OFF_ENABLE, rd, resp);
        check(rd, 32'h0000_005A);
        // Unmapped place must refuse and leave enables alone
        axi_wr(8'h0C, 32'h0000_00FF, resp);
        check({30'h0, resp}, {30'h0, UIEM_RESP_SLVERR});
        axi_rd(8'h0C, rd, resp);
        check({30'h0, resp}, {30'h0, UIEM_RESP_SLVERR});
        axi_rd(UIEM_OFF_ENABLE, rd, resp);
        check(rd, 32'h0000_005A);
        axi_wr(UIEM_OFF_ENABLE, 32'h0000_0000, resp);
        $display("test reset_and_access done");
    endtask

    // Each event: masked first, then unmasked, then cleared
    task automatic test_gating(input logic host);
        logic exp_irq;
        axi_wr(UIEM_OFF_ROLE, {31'h0, host}, resp);
        for (int i = 0; i < UIEM_NUM_EVT; i++) begin
            axi_wr(UIEM_OFF_ENABLE, 32'h0000_00FF & ~(32'h1 << i), resp);
            pulse((i == 0 && host) ? 8 : i);
            check({31'h0, usb_irq}, 32'h0000_0000);
            axi_rd(UIEM_OFF_STATUS, rd, resp);
            check(rd, 32'h1 << i);
            axi_wr(UIEM_OFF_ENABLE, 32'h1 << i, resp);
            repeat (2) @(posedge clk_sys);
            exp_irq = !(i == UIEM_BIT_ATTACH && !host);
            // attach only as host; others always
            check({31'h0, usb_irq}, {31'h0, exp_irq});
            axi_wr(UIEM_OFF_STATUS, 32'h1 << i, resp);
            repeat (2) @(posedge clk_sys);
            check({31'h0, usb_irq}, 32'h0000_0000);
        end
        // Wrong-role source for bit 0 must not raise anything
        axi_wr(UIEM_OFF_ENABLE, 32'h0000_0001, resp);
        pulse(host ? 0 : 8);
        check({31'h0, usb_irq}, 32'h0000_0000);
        axi_rd(UIEM_OFF_STATUS, rd, resp);
        check(rd, 32'h0000_0000);
        $display("test gating role %0d done", host);
    endtask

    // Low clock enable must keep an event from being captured
    task automatic test_clock_enable();
        axi_wr(UIEM_OFF_ENABLE, 32'h0000_0010, resp);
        @(posedge clk_sys);
        ce <= 1'b0;
        evt[4] <= 1'b1;
        @(posedge clk_sys);
        evt[4] <= 1'b0;
        repeat (3) @(posedge clk_sys);
        ce <= 1'b1;
        repeat (2) @(posedge clk_sys);
        check({31'h0, usb_irq}, 32'h0000_0000);
        axi_rd(UIEM_OFF_STATUS, rd, resp);
        check(rd, 32'h0000_0000);
        $display("test clock_enable done");
    endtask

    task automatic test_word_clear();
        axi_wr(UIEM_OFF_ENABLE, 32'h0000_0028, resp);
        pulse(3);
        pulse(5);
        axi_wr(UIEM_OFF_STATUS, 32'h0000_0008, resp);
        axi_rd(UIEM_OFF_STATUS, rd, resp);
        check(rd, 32'h0000_0020);
        repeat (2) @(posedge clk_sys);
        check({31'h0, usb_irq}, 32'h0000_0001);
        axi_wr(UIEM_OFF_STATUS, 32'h0000_0020, resp);
        repeat (2) @(posedge clk_sys);
        check({31'h0, usb_irq}, 32'h0000_0000);
        $display("test word_clear done");
    endtask

    initial begin
        repeat (8) @(posedge clk_sys);
        rst <= 1'b0;
        test_reset_and_access();
        test_gating(1'b0);
        test_gating(1'b1);
        test_clock_enable();
        test_word_clear();
        end_of_test();
    end
endmodule

// file: logic/uiem_flag_bank.sv
// Sticky event flags with write-one-to-clear
`timescale 1ns/1ps
module uiem_flag_bank
    import uiem_pkg::*;
#(
    parameter int WIDTH = 8
) (
    input wire logic clk_sys, // System clock
    input wire logic rst, // Sync reset, high
    input wire logic ce, // Clock enable
    input wire logic [WIDTH-1:0] set_vec, // Event pulses
    input wire logic [WIDTH-1:0] clr_vec, // Clear requests
    output logic [WIDTH-1:0] flag_reg // Sticky flags
);
    // ==========================================================
    // Per-bit flags
    genvar i;
    generate
        for (i = 0; i < WIDTH; i++) begin : g_flag
            // Set beats clear so no event is lost
            always_ff @(posedge clk_sys) begin
                if (rst) begin
                    flag_reg[i] <= UIEM_RST_STATUS[i];
                end else if (ce) begin
                    if (set_vec[i]) begin
                        flag_reg[i] <= 1'b1;
                    end else if (clr_vec[i]) begin
                        flag_reg[i] <= 1'b0;
                    end
                end
            end
        end
    endgenerate
endmodule

// file: logic/uiem_pkg.sv
// Constants for the USB interrupt enable mask block
package uiem_pkg;
    // ==========================================================
    // Register byte offsets
    localparam logic [7:0] UIEM_OFF_STATUS = 8'h00;
    localparam logic [7:0] UIEM_OFF_ENABLE = 8'h04;
    localparam logic [7:0] UIEM_OFF_ROLE = 8'h08;
    // ==========================================================
    // Field positions, shared by status and enable; UIEM_BIT_HOST is the role register bit
    localparam int UIEM_BIT_RESET_UNPLUG = 0;
    localparam int UIEM_BIT_ERROR = 1;
    localparam int UIEM_BIT_FRAME = 2;
    localparam int UIEM_BIT_TOKEN = 3;
    localparam int UIEM_BIT_IDLE = 4;
    localparam int UIEM_BIT_RESUME = 5;
    localparam int UIEM_BIT_ATTACH = 6;
    localparam int UIEM_BIT_STALL = 7;
    localparam int UIEM_BIT_HOST = 0;
    localparam int UIEM_NUM_EVT = 8;
    // ==========================================================
    // Reset values
    localparam logic [7:0] UIEM_RST_ENABLE = 8'h00;
    localparam logic [7:0] UIEM_RST_STATUS = 8'h00;
    localparam logic UIEM_RST_HOST = 1'b0;
    // ==========================================================
    // Bus answers
    localparam logic [1:0] UIEM_RESP_OKAY = 2'h0;
    localparam logic [1:0] UIEM_RESP_SLVERR = 2'h2;
    typedef enum {UIEM_IDLE, UIEM_BUSY} uiem_bus_e;
endpackage

// file: logic/uiem_top.sv
// USB interrupt enable mask with AXI4-Lite register access
//
// Implementation choices: the register addresses and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
module uiem_top
    import uiem_pkg::*;
#(
    parameter int ADDR_W = 8
) (
    input wire logic clk_sys, // System clock, 40 MHz
    input wire logic rst, // Sync reset, high
    input wire logic ce, // Clock enable, freezes all
    input wire logic evt_stall, // Stall handshake sent
    input wire logic evt_attach, // Peripheral attached
    input wire logic evt_resume, // Resume signalling seen
    input wire logic evt_idle, // Bus idle detected
    input wire logic evt_token_done, // Token processing done
    input wire logic evt_frame_start, // Start-of-frame
    input wire logic evt_error_summary, // Unmasked error present
    input wire logic evt_bus_reset, // Bus reset, peripheral
    input wire logic evt_unplug, // Detach, host
    input wire logic [ADDR_W-1:0] s_axi_awaddr, // Write address
    input wire logic [2:0] s_axi_awprot, // Unused protection
    input wire logic s_axi_awvalid, // Write address valid
    output logic s_axi_awready, // Write address ready
    input wire logic [31:0] s_axi_wdata, // Write data
    input wire logic [3:0] s_axi_wstrb, // Write strobes
    input wire logic s_axi_wvalid, // Write data valid
    output logic s_axi_wready, // Write data ready
    output logic [1:0] s_axi_bresp, // Write response
    output logic s_axi_bvalid, // Write response valid
    input wire logic s_axi_bready, // Write response ready
    input wire logic [ADDR_W-1:0] s_axi_araddr, // Read address
    input wire logic [2:0] s_axi_arprot, // Unused protection
    input wire logic s_axi_arvalid, // Read address valid
    output logic s_axi_arready, // Read address ready
    output logic [31:0] s_axi_rdata, // Read data
    output logic [1:0] s_axi_rresp, // Read response
    output logic s_axi_rvalid, // Read data valid
    input wire logic s_axi_rready, // Read data ready
    output logic usb_irq // Interrupt request, level
);
    // ==========================================================
    // Declarations
    localparam int N = UIEM_NUM_EVT;
    uiem_bus_e wr_state_reg;
    uiem_bus_e rd_state_reg;
    logic aw_held_reg;
    logic w_held_reg;
    logic [ADDR_W-1:0] aw_addr_reg;
    logic [31:0] w_data_reg;
    logic [3:0] w_strb_reg;
    logic [N-1:0] usb_interrupt_enable_reg;
    logic host_role_reg;
    logic [N-1:0] flag_reg;
    logic [N-1:0] set_vec;
    logic [N-1:0] clr_vec;
    logic [N-1:0] eff_en;
    logic irq_next;
    logic do_wr;
    logic wr_hit_status;
    logic wr_hit_enable;
    logic wr_hit_role;
    logic wr_mapped;
    logic [31:0] rd_value;
    logic rd_mapped;

    // ==========================================================
    // Event capture
    // bit 0 source follows role
    always_comb begin
        set_vec = '0;
        set_vec[UIEM_BIT_STALL] = evt_stall;
        set_vec[UIEM_BIT_ATTACH] = evt_attach;
        set_vec[UIEM_BIT_RESUME] = evt_resume;
        set_vec[UIEM_BIT_IDLE] = evt_idle;
        set_vec[UIEM_BIT_TOKEN] = evt_token_done;
        set_vec[UIEM_BIT_FRAME] = evt_frame_start;
        set_vec[UIEM_BIT_ERROR] = evt_error_summary;
        set_vec[UIEM_BIT_RESET_UNPLUG] =
            host_role_reg ? evt_unplug : evt_bus_reset;
    end

    // clear by ones in a word write
    assign clr_vec = (do_wr && wr_hit_status && w_strb_reg[0]) ?
        w_data_reg[N-1:0] : '0;

    uiem_flag_bank #(
        .WIDTH(N)
    ) u_flags (
        .clk_sys(clk_sys),
        .rst(rst),
        .ce(ce),
        .set_vec(set_vec),
        .clr_vec(clr_vec),
        .flag_reg(flag_reg)
    );

    // ==========================================================
    // Enable gating
    // attach enable only in host role
    always_comb begin
        eff_en = usb_interrupt_enable_reg;
        if (!host_role_reg) begin
            eff_en[UIEM_BIT_ATTACH] = 1'b0;
        end
    end

    assign irq_next = |(flag_reg & eff_en);

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            usb_irq <= 1'b0;
        end else if (ce) begin
            usb_irq <= irq_next;
        end
    end

    // ==========================================================
    // Write channel
    assign do_wr = aw_held_reg && w_held_reg &&
        (wr_state_reg == UIEM_IDLE);
    assign wr_hit_status =
        aw_addr_reg[ADDR_W-1:2] == UIEM_OFF_STATUS[ADDR_W-1:2];
    assign wr_hit_enable =
        aw_addr_reg[ADDR_W-1:2] == UIEM_OFF_ENABLE[ADDR_W-1:2];
    assign wr_hit_role =
        aw_addr_reg[ADDR_W-1:2] == UIEM_OFF_ROLE[ADDR_W-1:2];
    assign wr_mapped = wr_hit_status || wr_hit_enable || wr_hit_role;

    // Address and data may arrive in either order
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            aw_held_reg <= 1'b0;
            w_held_reg <= 1'b0;
            s_axi_awready <= 1'b1;
            s_axi_wready <= 1'b1;
            aw_addr_reg <= '0;
            w_data_reg <= '0;
            w_strb_reg <= '0;
        end else if (ce) begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_held_reg <= 1'b1;
                aw_addr_reg <= s_axi_awaddr;
                s_axi_awready <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_held_reg <= 1'b1;
                w_data_reg <= s_axi_wdata;
                w_strb_reg <= s_axi_wstrb;
                s_axi_wready <= 1'b0;
            end
            if (do_wr) begin
                aw_held_reg <= 1'b0;
                w_held_reg <= 1'b0;
            end
            if (s_axi_bvalid && s_axi_bready) begin
                s_axi_awready <= 1'b1;
                s_axi_wready <= 1'b1;
            end
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            wr_state_reg <= UIEM_IDLE;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= UIEM_RESP_OKAY;
        end else if (ce) begin
            case (wr_state_reg)
                UIEM_IDLE: begin
                    if (do_wr) begin
                        s_axi_bvalid <= 1'b1;
                        s_axi_bresp <= wr_mapped ?
                            UIEM_RESP_OKAY : UIEM_RESP_SLVERR;
                        wr_state_reg <= UIEM_BUSY;
                    end
                end
                UIEM_BUSY: begin
                    if (s_axi_bready) begin
                        s_axi_bvalid <= 1'b0;
                        wr_state_reg <= UIEM_IDLE;
                    end
                end
                default: begin
                    s_axi_bvalid <= 1'b0;
                    wr_state_reg <= UIEM_IDLE;
                end
            endcase
        end
    end

    // ==========================================================
    // Enable and role registers
    // eight bits, upper three bytes dropped
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            usb_interrupt_enable_reg <= UIEM_RST_ENABLE;
        end else if (ce && do_wr && wr_hit_enable && w_strb_reg[0]) begin
            usb_interrupt_enable_reg <= w_data_reg[N-1:0];
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            host_role_reg <= UIEM_RST_HOST;
        end else if (ce && do_wr && wr_hit_role && w_strb_reg[0]) begin
            host_role_reg <= w_data_reg[UIEM_BIT_HOST];
        end
    end

    // ==========================================================
    // Read channel
    // unimplemented bits read zero
    always_comb begin
        rd_value = '0;
        rd_mapped = 1'b1;
        if (s_axi_araddr[ADDR_W-1:2] ==
                UIEM_OFF_STATUS[ADDR_W-1:2]) begin
            rd_value[N-1:0] = flag_reg;
        end else if (s_axi_araddr[ADDR_W-1:2] ==
                UIEM_OFF_ENABLE[ADDR_W-1:2]) begin
            rd_value[N-1:0] = usb_interrupt_enable_reg;
        end else if (s_axi_araddr[ADDR_W-1:2] ==
                UIEM_OFF_ROLE[ADDR_W-1:2]) begin
            rd_value[UIEM_BIT_HOST] = host_role_reg;
        end else begin
            rd_mapped = 1'b0;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            rd_state_reg <= UIEM_IDLE;
            s_axi_arready <= 1'b1;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= '0;
            s_axi_rresp <= UIEM_RESP_OKAY;
        end else if (ce) begin
            case (rd_state_reg)
                UIEM_IDLE: begin
                    if (s_axi_arvalid) begin
                        s_axi_arready <= 1'b0;
                        s_axi_rvalid <= 1'b1;
                        s_axi_rdata <= rd_value;
                        s_axi_rresp <= rd_mapped ?
                            UIEM_RESP_OKAY : UIEM_RESP_SLVERR;
                        rd_state_reg <= UIEM_BUSY;
                    end
                end
                UIEM_BUSY: begin
                    if (s_axi_rready) begin
                        s_axi_rvalid <= 1'b0;
                        s_axi_arready <= 1'b1;
                        rd_state_reg <= UIEM_IDLE;
                    end
                end
                default: begin
                    s_axi_rvalid <= 1'b0;
                    s_axi_arready <= 1'b1;
                    rd_state_reg <= UIEM_IDLE;
                end
            endcase
        end
    end

    // ==========================================================
    // Checks
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (rst);

    chk_irq_follows_en: assert property (
        ce |=> usb_irq == $past(|(flag_reg & eff_en)))
        else $error("interrupt does not follow enabled flags");

    chk_attach_host_only: assert property (
        (ce && !host_role_reg &&
            (flag_reg & ~(8'h40)) == 8'h00) |=> !usb_irq)
        else $error("attach raised interrupt outside host role");

    chk_bit0_role_src: assert property (
        (ce && !host_role_reg && evt_unplug && !evt_bus_reset &&
            !flag_reg[0]) |=> !flag_reg[0])
        else $error("detach event set flag in peripheral role");

    chk_token_enable: assert property (
        (ce && flag_reg == 8'h08 && usb_interrupt_enable_reg[3])
            |=> usb_irq)
        else $error("token done did not interrupt");

    chk_idle_enable: assert property (
        (ce && flag_reg == 8'h10 && !usb_interrupt_enable_reg[4])
            |=> !usb_irq)
        else $error("masked idle raised interrupt");

    chk_resume_enable: assert property (
        (ce && flag_reg == 8'h20 && usb_interrupt_enable_reg[5])
            |=> usb_irq)
        else $error("resume did not interrupt");

    chk_error_enable: assert property (
        (ce && flag_reg == 8'h02 && usb_interrupt_enable_reg[1])
            |=> usb_irq)
        else $error("error summary did not interrupt");

    chk_stall_sof_mask: assert property (
        (ce && (flag_reg & ~(8'h84)) == 8'h00 &&
            (usb_interrupt_enable_reg & 8'h84) == 8'h00) |=> !usb_irq)
        else $error("masked stall or frame raised interrupt");

    chk_enable_write: assert property (
        (ce && do_wr && wr_hit_enable && w_strb_reg[0]) |=>
            usb_interrupt_enable_reg == $past(w_data_reg[7:0]))
        else $error("enable write not stored");

    chk_upper_zero: assert property (
        s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h000000)
        else $error("upper read bits not zero");

    chk_set_wins: assert property (
        (ce && set_vec[3]) |=> flag_reg[3])
        else $error("event lost against clear");

    cov_irq_raised: cover property (ce && !usb_irq ##1 usb_irq);
    cov_flag_cleared: cover property (
        ce && do_wr && wr_hit_status && (clr_vec != 8'h00));
    cov_host_attach: cover property (
        host_role_reg && flag_reg[6] && usb_interrupt_enable_reg[6]);
    cov_bad_read: cover property (
        s_axi_rvalid && s_axi_rresp == UIEM_RESP_SLVERR);
endmodule
